// >>> rtl/eil_top.sv
// external interrupt latch block: registers, two input channels, interrupt outputs
`timescale 1ns/100ps
`default_nettype none
module eil_top (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rd_data_out,
	input wire logic dedicated_int_pin_n_in,
	input wire logic shared_int_pin_n_in,
	input wire logic [1:0] vec_fetch_in,
	input wire logic break_state_in,
	output logic [1:0] cpu_req_out,
	output logic shared_pullup_en_out,
	output logic dedicated_pullup_en_out,
	output logic irq_out
);
	eil_pkg::eil_top_state_t state_ff;
	eil_pkg::eil_top_state_t nxt_state;
	logic [eil_pkg::NUM_CH-1:0] pin_vec;
	logic [eil_pkg::NUM_CH-1:0] latch_vec;
	logic [eil_pkg::NUM_CH-1:0] rise_vec;
	logic [eil_pkg::NUM_CH-1:0] ack_wr;
	logic clr_ok;
	logic hit_ded;
	logic hit_sh;
	logic hit_brk;
	logic hit_stat;
	logic hit_en;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// status/control read image of one channel
	function automatic logic [7:0] scr_image(input logic flag, input logic mask,
		input logic sense, input logic pud);
		logic [7:0] v;
		v = eil_pkg::RD_ZERO;
		v[eil_pkg::BIT_FLAG] = flag;
		v[eil_pkg::BIT_MASK] = mask;
		v[eil_pkg::BIT_SENSE] = sense;
		v[eil_pkg::BIT_PUD] = pud;
		return v;
	endfunction

	assign pin_vec[eil_pkg::CH_DED] = dedicated_int_pin_n_in;
	assign pin_vec[eil_pkg::CH_SH] = shared_int_pin_n_in;

	eil_chan_if ch_if [eil_pkg::NUM_CH] ();

	// one channel per input, each with its own control bits
	for (genvar gi = 0; gi < eil_pkg::NUM_CH; gi++) begin : g_ch
		assign ch_if[gi].pin_n = pin_vec[gi];
		assign ch_if[gi].sense = state_ff.sense[gi];
		assign ch_if[gi].ack_wr = ack_wr[gi];
		assign ch_if[gi].vec_fetch = vec_fetch_in[gi];
		assign ch_if[gi].clr_ok = clr_ok;
		assign latch_vec[gi] = ch_if[gi].latch;
		assign rise_vec[gi] = ch_if[gi].rise;
		eil_chan u_chan (
			.clk_sys_in(clk_sys_in),
			.rst_in(rst_in),
			.ch(ch_if[gi])
		);
	end

	always_comb begin
		nxt_state = state_ff;
		hit_ded = reg_hit(addr_in, eil_pkg::ADDR_DED);
		hit_sh = reg_hit(addr_in, eil_pkg::ADDR_SHARED);
		hit_brk = reg_hit(addr_in, eil_pkg::ADDR_BRK);
		hit_stat = reg_hit(addr_in, eil_pkg::ADDR_EVT_STAT);
		hit_en = reg_hit(addr_in, eil_pkg::ADDR_EVT_MASK);
		// ack writes only act outside break, or in break when enabled
		clr_ok = ~break_state_in | state_ff.break_clear_enable;
		ack_wr[eil_pkg::CH_DED] = wr_in & hit_ded & wr_data_in[eil_pkg::BIT_ACK];
		ack_wr[eil_pkg::CH_SH] = wr_in & hit_sh & wr_data_in[eil_pkg::BIT_ACK];
		if (wr_in && hit_ded) begin
			nxt_state.mask[eil_pkg::CH_DED] = wr_data_in[eil_pkg::BIT_MASK];
			nxt_state.sense[eil_pkg::CH_DED] = wr_data_in[eil_pkg::BIT_SENSE];
		end
		if (wr_in && hit_sh) begin
			nxt_state.mask[eil_pkg::CH_SH] = wr_data_in[eil_pkg::BIT_MASK];
			nxt_state.sense[eil_pkg::CH_SH] = wr_data_in[eil_pkg::BIT_SENSE];
			nxt_state.sh_pud = wr_data_in[eil_pkg::BIT_PUD];
		end
		if (wr_in && hit_brk) begin
			nxt_state.break_clear_enable = wr_data_in[eil_pkg::BIT_BREAK_CLEAR_ENABLE];
		end
		if (wr_in && hit_en) begin
			nxt_state.evt_en = wr_data_in[eil_pkg::NUM_CH-1:0];
		end
		// write one to clear; a new event in the same cycle wins
		nxt_state.evt_stat = state_ff.evt_stat;
		if (wr_in && hit_stat) begin
			nxt_state.evt_stat = state_ff.evt_stat & ~wr_data_in[eil_pkg::NUM_CH-1:0];
		end
		nxt_state.evt_stat = nxt_state.evt_stat | rise_vec;
		// read data valid only in the cycle after the strobe; unmapped reads zero
		nxt_state.rdata = eil_pkg::RD_ZERO;
		if (rd_in) begin
			if (hit_ded) begin
				nxt_state.rdata = scr_image(latch_vec[eil_pkg::CH_DED],
					state_ff.mask[eil_pkg::CH_DED], state_ff.sense[eil_pkg::CH_DED], 1'b0);
			end else if (hit_sh) begin
				nxt_state.rdata = scr_image(latch_vec[eil_pkg::CH_SH],
					state_ff.mask[eil_pkg::CH_SH], state_ff.sense[eil_pkg::CH_SH],
					state_ff.sh_pud);
			end else if (hit_brk) begin
				nxt_state.rdata[eil_pkg::BIT_BREAK_CLEAR_ENABLE] = state_ff.break_clear_enable;
			end else if (hit_stat) begin
				nxt_state.rdata[eil_pkg::NUM_CH-1:0] = state_ff.evt_stat;
			end else if (hit_en) begin
				nxt_state.rdata[eil_pkg::NUM_CH-1:0] = state_ff.evt_en;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= eil_pkg::TOP_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rd_data_out = state_ff.rdata;
	assign cpu_req_out = latch_vec & ~state_ff.mask;
	assign shared_pullup_en_out = ~state_ff.sh_pud;
	assign dedicated_pullup_en_out = 1'b1;
	assign irq_out = |(state_ff.evt_stat & state_ff.evt_en);

	req_masked_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		state_ff.mask[eil_pkg::CH_DED] |-> !cpu_req_out[eil_pkg::CH_DED])
		else $error("masked dedicated request reached the cpu");

	req_raised_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!state_ff.mask[eil_pkg::CH_SH] && rise_vec[eil_pkg::CH_SH]
		|=> cpu_req_out[eil_pkg::CH_SH])
		else $error("unmasked shared request not raised");

	ack_reads_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rd_in && (hit_ded || hit_sh) |=> !rd_data_out[eil_pkg::BIT_ACK])
		else $error("ack bit did not read as zero");

	flag_read_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rd_in && hit_ded |=> rd_data_out[eil_pkg::BIT_FLAG] == $past(latch_vec[eil_pkg::CH_DED]))
		else $error("pending flag differs from latch");

	vec_only_one_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		vec_fetch_in == 2'b01 && latch_vec[eil_pkg::CH_SH] && !ack_wr[eil_pkg::CH_SH]
		|=> latch_vec[eil_pkg::CH_SH])
		else $error("vector fetch cleared the other latch");

	brk_ignored_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		break_state_in && !state_ff.break_clear_enable && ack_wr[eil_pkg::CH_DED]
		&& !vec_fetch_in[eil_pkg::CH_DED] && latch_vec[eil_pkg::CH_DED]
		|=> latch_vec[eil_pkg::CH_DED])
		else $error("ack in break cleared latch while disabled");

	brk_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		break_state_in && state_ff.break_clear_enable && ack_wr[eil_pkg::CH_DED]
		&& !state_ff.sense[eil_pkg::CH_DED] && pin_vec[eil_pkg::CH_DED]
		&& $past(pin_vec[eil_pkg::CH_DED]) && $past(pin_vec[eil_pkg::CH_DED], 2)
		|=> !latch_vec[eil_pkg::CH_DED])
		else $error("enabled ack in break did not clear latch");

	pullup_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		wr_in && hit_sh |=> shared_pullup_en_out == !$past(wr_data_in[eil_pkg::BIT_PUD]))
		else $error("shared pullup does not follow its control bit");

	indep_cfg_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		wr_in && hit_sh |=> $stable(state_ff.mask[eil_pkg::CH_DED])
		&& $stable(state_ff.sense[eil_pkg::CH_DED]))
		else $error("shared write changed dedicated config");

	unmapped_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rd_in && !(hit_ded || hit_sh || hit_brk || hit_stat || hit_en) |=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");

	upper_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rd_in && hit_ded |=> rd_data_out[7:4] == 4'h0)
		else $error("unimplemented bits read nonzero");

	irq_event_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		rise_vec[eil_pkg::CH_DED] && state_ff.evt_en[eil_pkg::CH_DED] |=> irq_out)
		else $error("enabled event did not raise irq");

	cov_vec_clear: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		latch_vec[eil_pkg::CH_DED] && vec_fetch_in[eil_pkg::CH_DED]
		##1 !latch_vec[eil_pkg::CH_DED]);

	cov_brk_ignore: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		break_state_in && !state_ff.break_clear_enable && ack_wr[eil_pkg::CH_SH] && latch_vec[eil_pkg::CH_SH]);

	cov_level_hold: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		state_ff.sense[eil_pkg::CH_SH] && ack_wr[eil_pkg::CH_SH] ##1 latch_vec[eil_pkg::CH_SH]);

	cov_irq: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(irq_out));
endmodule
`default_nettype wire

// >>> rtl/eil_pkg.sv
// constants, field layout and state types for the external interrupt latch block
// Function
// - two maskable interrupt inputs: one dedicated pin, one shared with a port pin
// - each input has its own ack, mask and sense bits, fully independent
// - falling edge on a pin, or low level when sense is 1, sets that input's latch and requests the cpu
// - vector fetch acknowledges and clears only the latch that caused it
// - sense selectable: falling edge only, or falling edge plus low level
// - shared input pullup switched by a control bit; dedicated pullup always on
// - one 8-bit status/control register per input: dedicated 0x1e, shared 0x1c
// - mask bit set blocks the latched request from reaching the cpu
// - pending flag is read-only and reads 1 while the latch is set
// - writing 1 to ack clears the latch; ack reads 0 and resets to 0
// - in break state with break clear enable 1, ack writes clear the latch
// - a latch cleared in break state stays cleared after break ends
// - with break clear enable 0, ack writes during break are ignored
package eil_pkg;
	localparam int NUM_CH = 2;
	localparam int CH_DED = 0;
	localparam int CH_SH = 1;
	localparam logic [7:0] ADDR_SHARED = 8'h1c;
	localparam logic [7:0] ADDR_DED = 8'h1e;
	localparam logic [7:0] ADDR_BRK = 8'h20;
	localparam logic [7:0] ADDR_EVT_STAT = 8'h21;
	localparam logic [7:0] ADDR_EVT_MASK = 8'h22;
	localparam int BIT_SENSE = 0;
	localparam int BIT_MASK = 1;
	localparam int BIT_ACK = 2;
	localparam int BIT_FLAG = 3;
	localparam int BIT_PUD = 6;
	localparam int BIT_BREAK_CLEAR_ENABLE = 0;
	localparam logic [7:0] RD_ZERO = 8'h00;
	localparam logic PIN_IDLE = 1'b1;
	localparam logic BIT_RST = 1'b0;

	typedef struct packed {
		logic sync1_n;
		logic sync2_n;
		logic prev_n;
		logic latch;
	} eil_chan_state_t;

	localparam eil_chan_state_t CHAN_RST = '{PIN_IDLE, PIN_IDLE, PIN_IDLE, BIT_RST};

	typedef struct packed {
		logic [NUM_CH-1:0] mask;
		logic [NUM_CH-1:0] sense;
		logic sh_pud;
		logic break_clear_enable;
		logic [NUM_CH-1:0] evt_stat;
		logic [NUM_CH-1:0] evt_en;
		logic [7:0] rdata;
	} eil_top_state_t;

	localparam eil_top_state_t TOP_RST = '0;
endpackage

// >>> rtl/eil_chan_if.sv
// signals between the register side and one interrupt input channel
`timescale 1ns/100ps
`default_nettype none
interface eil_chan_if;
	logic pin_n;
	logic sense;
	logic ack_wr;
	logic vec_fetch;
	logic clr_ok;
	logic latch;
	logic rise;
	modport ctl (output pin_n, sense, ack_wr, vec_fetch, clr_ok, input latch, rise);
	modport chan (input pin_n, sense, ack_wr, vec_fetch, clr_ok, output latch, rise);
endinterface
`default_nettype wire

// >>> rtl/eil_chan.sv
// one interrupt input: pin synchroniser, edge/level detect and request latch
`timescale 1ns/100ps
`default_nettype none
module eil_chan (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	eil_chan_if.chan ch
);
	eil_pkg::eil_chan_state_t state_ff;
	eil_pkg::eil_chan_state_t nxt_state;
	logic fall;
	logic set;
	logic clr;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.sync1_n = ch.pin_n;
		nxt_state.sync2_n = state_ff.sync1_n;
		nxt_state.prev_n = state_ff.sync2_n;
		fall = state_ff.prev_n & ~state_ff.sync2_n;
		set = fall | (ch.sense & ~state_ff.sync2_n);
		clr = ch.vec_fetch | (ch.ack_wr & ch.clr_ok);
		if (set) begin
			nxt_state.latch = 1'b1;
		end else if (clr) begin
			nxt_state.latch = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= eil_pkg::CHAN_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign ch.latch = state_ff.latch;
	assign ch.rise = set & ~state_ff.latch;

	level_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ch.sense && !state_ff.sync2_n |=> state_ff.latch)
		else $error("low level in level mode did not hold latch");
	edge_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		state_ff.prev_n && !state_ff.sync2_n |=> state_ff.latch)
		else $error("falling edge did not set latch");
	latch_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		clr && !set |=> !state_ff.latch)
		else $error("clear request did not clear latch");
	edge_only_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!ch.sense && !fall && !state_ff.latch |=> !state_ff.latch)
		else $error("latch set without an edge in edge mode");
endmodule
`default_nettype wire

// >>> bench/eil_src_model.sv
// external interrupt sources: open-drain drivers on both interrupt pins
`timescale 1ns/100ps
`default_nettype none
module eil_src_model (
	input wire logic clk_sys_in,
	input wire logic [1:0] pull_low_in,
	input wire logic dedicated_pullup_en_in,
	input wire logic shared_pullup_en_in,
	output logic dedicated_int_pin_n_out,
	output logic shared_int_pin_n_out
);
	logic sh_last;
	logic ded_last;
	initial sh_last = 1'b1;
	initial ded_last = 1'b1;
	// a source only ever pulls low; released pins sit high while their pullup is enabled, otherwise they wander
	assign dedicated_int_pin_n_out = pull_low_in[0] ? 1'b0 :
		(dedicated_pullup_en_in ? 1'b1 : ~ded_last);
	// no pullup on a released shared pin: the line wanders
	assign shared_int_pin_n_out = pull_low_in[1] ? 1'b0 : (shared_pullup_en_in ? 1'b1 : ~sh_last);
	always @(posedge clk_sys_in) begin
		sh_last <= shared_int_pin_n_out;
		ded_last <= dedicated_int_pin_n_out;
	end
endmodule
`default_nettype wire

// >>> bench/eil_top_bench.sv
// self-checking bench for the external interrupt latch block
`timescale 1ns/100ps
`default_nettype none
module eil_top_bench;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [1:0] vec_fetch_in = 2'b00;
	logic break_state_in = 1'b0;
	logic [1:0] pull_low = 2'b00;
	logic [7:0] rd_data_out;
	logic [1:0] cpu_req_out;
	logic shared_pullup_en_out, dedicated_pullup_en_out, irq_out, ded_pin_n, sh_pin_n;
	int miscompares = 0;
	int n_checks = 0;
	always #2 clk_sys_in = ~clk_sys_in;
	eil_top uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.dedicated_int_pin_n_in(ded_pin_n), .shared_int_pin_n_in(sh_pin_n),
		.vec_fetch_in(vec_fetch_in), .break_state_in(break_state_in),
		.cpu_req_out(cpu_req_out), .shared_pullup_en_out(shared_pullup_en_out),
		.dedicated_pullup_en_out(dedicated_pullup_en_out), .irq_out(irq_out));
	eil_src_model src (.clk_sys_in(clk_sys_in), .pull_low_in(pull_low),
		.dedicated_pullup_en_in(dedicated_pullup_en_out),
		.shared_pullup_en_in(shared_pullup_en_out),
		.dedicated_int_pin_n_out(ded_pin_n), .shared_int_pin_n_out(sh_pin_n));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1;
		chk(rd_data_out, exp);
	endtask
	task automatic pulse(input logic [1:0] which);
		@(posedge clk_sys_in);
		pull_low <= which;
		repeat (3) @(posedge clk_sys_in);
		pull_low <= 2'b00;
		repeat (6) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic fetch(input logic [1:0] which);
		@(posedge clk_sys_in);
		vec_fetch_in <= which;
		@(posedge clk_sys_in);
		vec_fetch_in <= 2'b00;
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic results;
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		results();
	end
	initial begin
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1;
		chk({6'h0, cpu_req_out}, 8'h00);
		chk({6'h0, shared_pullup_en_out, dedicated_pullup_en_out}, 8'h03);
		rd(8'h1c, 8'h00);
		rd(8'h1e, 8'h00);
		wr(8'h22, 8'h03);
		pulse(2'b01);
		chk({6'h0, cpu_req_out}, 8'h01);
		chk({7'h0, irq_out}, 8'h01);
		rd(8'h1e, 8'h08);
		rd(8'h1c, 8'h00);
		rd(8'h21, 8'h01);
		wr(8'h21, 8'h01);
		chk({7'h0, irq_out}, 8'h00);
		wr(8'h1e, 8'h02);
		chk({6'h0, cpu_req_out}, 8'h00);
		rd(8'h1e, 8'h0a);
		wr(8'h1e, 8'h06);
		rd(8'h1e, 8'h02);
		wr(8'h1e, 8'h00);
		pulse(2'b11);
		chk({6'h0, cpu_req_out}, 8'h03);
		rd(8'h21, 8'h03);
		wr(8'h22, 8'h00);
		chk({7'h0, irq_out}, 8'h00);
		wr(8'h21, 8'h03);
		wr(8'h22, 8'h03);
		fetch(2'b01);
		chk({6'h0, cpu_req_out}, 8'h02);
		fetch(2'b10);
		chk({6'h0, cpu_req_out}, 8'h00);
		wr(8'h1c, 8'h01);
		@(posedge clk_sys_in);
		pull_low <= 2'b10;
		repeat (6) @(posedge clk_sys_in);
		wr(8'h1c, 8'h05);
		rd(8'h1c, 8'h09);
		wr(8'h1c, 8'h41);
		chk({7'h0, shared_pullup_en_out}, 8'h00);
		rd(8'h1c, 8'h49);
		wr(8'h1c, 8'h00);
		wr(8'h1c, 8'h04);
		rd(8'h1c, 8'h00);
		@(posedge clk_sys_in);
		pull_low <= 2'b00;
		pulse(2'b01);
		@(posedge clk_sys_in);
		break_state_in <= 1'b1;
		wr(8'h1e, 8'h04);
		rd(8'h1e, 8'h08);
		wr(8'h20, 8'h01);
		wr(8'h1e, 8'h04);
		@(posedge clk_sys_in);
		break_state_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rd(8'h1e, 8'h00);
		rd(8'h1e, 8'h00);
		wr(8'h20, 8'h00);
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
		wr(8'h1e, 8'hff);
		rd(8'h1e, 8'h03);
		rd(8'h1c, 8'h00);
		results();
	end
endmodule
`default_nettype wire
